//--- speif_pkg.sv
// package: constants and carrier types of the serial eeprom pin interface
package speif_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS         = 10;
   localparam int unsigned INTERNAL_WRITE_TIME_MS = 5;
   localparam int unsigned INTERNAL_WRITE_CYCLES  =
      (INTERNAL_WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned POWERUP_READ_DELAY_MS  = 1;
   localparam int unsigned POWERUP_WRITE_DELAY_MS = 1;
   localparam int unsigned POWERUP_CYCLES         =
      (POWERUP_READ_DELAY_MS * 1000000) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // frame layout
   // ---------------------------------------------------------------
   localparam int unsigned BYTE_BITS        = 8;
   localparam int unsigned CNT_W            = 3;
   localparam logic [2:0]  BIT_CNT_RESET    = 3'h0;
   localparam int unsigned GUARD_BIT_POS    = 7;
   localparam logic [7:0]  STATUS_RESET     = 8'h00;
   localparam logic [7:0]  CMD_WRITE_STATUS = 8'h01;
   localparam logic [7:0]  CMD_WRITE_DATA   = 8'h02;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic select_n;
      logic sclk;
      logic serial_in;
      logic pause_n;
      logic write_guard_n;
   } speif_pins_t;

   typedef struct packed {
      logic byte_valid;
      logic [7:0] byte_data;
      logic       first_byte;
   } speif_rx_t;

   typedef enum logic [1:0] {
      SPEIF_IDLE   = 2'b00,
      SPEIF_ACTIVE = 2'b01,
      SPEIF_PAUSED = 2'b11
   } speif_state_t;

endpackage : speif_pkg

//--- speif_sync.sv
// module: two-flop synchronisers for the pin group
module speif_sync #(
   parameter int unsigned WIDTH = 5
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   if (WIDTH < 1) begin : g_bad_width
      $error("speif_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second stage
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stage1   <= '1;
         sync_out <= '1;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : speif_sync

//--- speif_core.sv
// module: serial eeprom pin-level interface, device end
// Operation
// (RULE1) sample serial_in on each rising serial clock, modes (0,0) and (1,1)
// (RULE2) change serial_out on each falling serial clock edge
// (RULE3) select high floats serial_out, standby, internal write still completes
// (RULE4) host frames each transaction with select falling then rising
// (RULE5) guard pin high adds no write inhibition
// (RULE6) guard pin low with enable bit set refuses status writes
// (RULE7) host moves pause pin only while serial clock is low
// (RULE8) after pause, transfer resumes at the same bit position
// (RULE9) paused device floats serial_out, drives again on release
// (RULE10) host ties pause pin high when pausing is unused
// (RULE11) internal write finishes within 5 ms of closing select edge
// (RULE12) host waits up to 1 ms after power-up before access
// (RULE13) paused device ignores clock and data, counters frozen
module speif_core #(
   parameter int unsigned WRITE_CYCLES   = speif_pkg::INTERNAL_WRITE_CYCLES,
   parameter int unsigned POWERUP_CYCLES = speif_pkg::POWERUP_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        select_n,
   input  wire logic        sclk,
   input  wire logic        serial_in,
   input  wire logic        pause_n,
   input  wire logic        write_guard_n,
   input  wire logic [7:0]  tx_byte,
   output logic             serial_out,
   output logic             serial_out_oe_n,
   output logic             rx_valid,
   output logic [7:0]       rx_byte,
   output logic             rx_first,
   output logic             write_busy,
   output logic             ready,
   output logic [7:0]       status
);

   if (WRITE_CYCLES < 1 || WRITE_CYCLES > 32'h0fffffff) begin : g_bad_write
      $error("speif_core: WRITE_CYCLES out of range");
   end
   if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 32'h0fffffff) begin : g_bad_powerup
      $error("speif_core: POWERUP_CYCLES out of range");
   end

   // ---------------------------------------------------------------
   // pin synchronisation and edge detection
   // ---------------------------------------------------------------
   speif_pkg::speif_pins_t pins_raw;
   speif_pkg::speif_pins_t pins;
   logic                   sclk_prev;
   logic                   sel_prev;

   assign pins_raw = '{select_n: select_n, sclk: sclk, serial_in: serial_in,
                       pause_n: pause_n, write_guard_n: write_guard_n};

   speif_sync #(.WIDTH(5)) u_sync (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (pins_raw),
      .sync_out (pins)
   );

   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;
   logic sel_fall;
   assign sclk_rise = pins.sclk & ~sclk_prev;
   assign sclk_fall = ~pins.sclk & sclk_prev;
   assign sel_rise  = pins.select_n & ~sel_prev;
   assign sel_fall  = ~pins.select_n & sel_prev;

   // ---------------------------------------------------------------
   // framing state
   // ---------------------------------------------------------------
   speif_pkg::speif_state_t state;
   speif_pkg::speif_state_t next_state;
   logic [2:0]  bit_cnt;
   logic [2:0]  next_bit_cnt;
   logic [7:0]  shift_in;
   logic [7:0]  next_shift_in;
   logic [7:0]  shift_out;
   logic [7:0]  next_shift_out;
   logic        next_serial_out;
   logic        next_oe_n;
   logic        next_rx_valid;
   logic [7:0]  next_rx_byte;
   logic        next_rx_first;
   logic        first_pending;
   logic        next_first_pending;
   logic [7:0]  opcode;
   logic [7:0]  next_opcode;
   logic        write_seen;
   logic        next_write_seen;
   logic        byte_done;

   assign byte_done = (bit_cnt == 3'h7);

   always_comb begin
      next_state         = state;
      next_bit_cnt       = bit_cnt;
      next_shift_in      = shift_in;
      next_shift_out     = shift_out;
      next_serial_out    = serial_out;
      next_oe_n          = serial_out_oe_n;
      next_rx_valid      = 1'b0;
      next_rx_byte       = rx_byte;
      next_rx_first      = rx_first;
      next_first_pending = first_pending;
      next_opcode        = opcode;
      next_write_seen    = write_seen;
      unique case (state)
         speif_pkg::SPEIF_IDLE: begin
            next_oe_n = 1'b1;                                          // RULE3
            if (sel_fall && ready) begin                               // RULE4
               next_state         = speif_pkg::SPEIF_ACTIVE;
               next_bit_cnt       = speif_pkg::BIT_CNT_RESET;
               next_first_pending = 1'b1;
               next_write_seen    = 1'b0;
               next_shift_out     = tx_byte;
               next_serial_out    = tx_byte[7];
               next_oe_n          = 1'b0;
            end
         end
         speif_pkg::SPEIF_ACTIVE: begin
            if (pins.select_n) begin
               next_state = speif_pkg::SPEIF_IDLE;                     // RULE4
               next_oe_n  = 1'b1;                                      // RULE3
            end else if (!pins.pause_n) begin
               next_state = speif_pkg::SPEIF_PAUSED;
               next_oe_n  = 1'b1;                                      // RULE9
            end else begin
               if (sclk_rise) begin                                    // RULE1
                  next_shift_in = {shift_in[6:0], pins.serial_in};
                  next_bit_cnt  = bit_cnt + 3'h1;
                  if (byte_done) begin
                     next_rx_valid      = 1'b1;
                     next_rx_byte       = {shift_in[6:0], pins.serial_in};
                     next_rx_first      = first_pending;
                     next_first_pending = 1'b0;
                     if (first_pending) begin
                        next_opcode = {shift_in[6:0], pins.serial_in};
                     end else begin
                        next_write_seen = 1'b1;
                     end
                  end
               end
               if (sclk_fall) begin                                    // RULE2
                  if (bit_cnt == speif_pkg::BIT_CNT_RESET) begin
                     next_shift_out  = tx_byte;
                     next_serial_out = tx_byte[7];
                  end else begin
                     next_shift_out  = {shift_out[6:0], 1'b0};
                     next_serial_out = shift_out[6];
                  end
               end
            end
         end
         speif_pkg::SPEIF_PAUSED: begin
            next_oe_n = 1'b1;                                          // RULE13
            if (pins.select_n) begin
               next_state = speif_pkg::SPEIF_IDLE;
            end else if (pins.pause_n) begin
               next_state = speif_pkg::SPEIF_ACTIVE;                   // RULE8
               next_oe_n  = 1'b0;                                      // RULE9
            end
         end
         default: begin
            next_state = speif_pkg::SPEIF_IDLE;
            next_oe_n  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state           <= speif_pkg::SPEIF_IDLE;
         bit_cnt         <= speif_pkg::BIT_CNT_RESET;
         shift_in        <= 8'h00;
         shift_out       <= 8'h00;
         serial_out      <= 1'b0;
         serial_out_oe_n <= 1'b1;
         rx_valid        <= 1'b0;
         rx_byte         <= 8'h00;
         rx_first        <= 1'b0;
         first_pending   <= 1'b0;
         opcode          <= 8'h00;
         write_seen      <= 1'b0;
         sclk_prev       <= 1'b1; // synchroniser resets high: no false edge
         sel_prev        <= 1'b1;
      end else begin
         state           <= next_state;
         bit_cnt         <= next_bit_cnt;
         shift_in        <= next_shift_in;
         shift_out       <= next_shift_out;
         serial_out      <= next_serial_out;
         serial_out_oe_n <= next_oe_n;
         rx_valid        <= next_rx_valid;
         rx_byte         <= next_rx_byte;
         rx_first        <= next_rx_first;
         first_pending   <= next_first_pending;
         opcode          <= next_opcode;
         write_seen      <= next_write_seen;
         sclk_prev       <= pins.sclk;
         sel_prev        <= pins.select_n;
      end
   end

   // ---------------------------------------------------------------
   // status byte, write guard and self-timed write
   // ---------------------------------------------------------------
   logic        status_blocked;
   logic        commit;
   logic        commit_status;
   logic [31:0] wr_cnt;
   logic [31:0] next_wr_cnt;
   logic [31:0] pu_cnt;
   logic [31:0] next_pu_cnt;
   logic [7:0]  next_status;
   logic        next_write_busy;
   logic        next_ready;

   // the guard pin only blocks status writes, and only with the enable bit set
   assign status_blocked = ~pins.write_guard_n & status[speif_pkg::GUARD_BIT_POS]; // RULE6 RULE5
   assign commit         = (state == speif_pkg::SPEIF_ACTIVE) && sel_rise && write_seen
                           && bit_cnt == speif_pkg::BIT_CNT_RESET
                           && (opcode == speif_pkg::CMD_WRITE_DATA
                               || (opcode == speif_pkg::CMD_WRITE_STATUS && !status_blocked));
   assign commit_status  = commit && opcode == speif_pkg::CMD_WRITE_STATUS;

   always_comb begin
      next_status     = status;
      next_wr_cnt     = wr_cnt;
      next_write_busy = write_busy;
      next_pu_cnt     = pu_cnt;
      next_ready      = ready;
      // power-up hold-off keeps the host out until the delay is over
      if (pu_cnt != 32'h0) begin
         next_pu_cnt = pu_cnt - 32'h1;
      end else begin
         next_ready = 1'b1;
      end
      if (commit) begin                                                // RULE11
         next_wr_cnt     = WRITE_CYCLES[31:0] - 32'h1;
         next_write_busy = 1'b1;
         if (commit_status) begin
            next_status = rx_byte;
         end
      end else if (wr_cnt != 32'h0) begin                              // RULE3
         next_wr_cnt = wr_cnt - 32'h1;
      end else begin
         next_write_busy = 1'b0;
      end
      next_status[0] = next_write_busy;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         status     <= speif_pkg::STATUS_RESET;
         wr_cnt     <= 32'h0;
         write_busy <= 1'b0;
         pu_cnt     <= POWERUP_CYCLES[31:0];
         ready      <= 1'b0;
      end else begin
         status     <= next_status;
         wr_cnt     <= next_wr_cnt;
         write_busy <= next_write_busy;
         pu_cnt     <= next_pu_cnt;
         ready      <= next_ready;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_commit;
      commit;
   endsequence

   AST_FLOAT_DESELECT: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
      pins.select_n |=> serial_out_oe_n)
      else $error("serial_out driven while deselected");
   AST_FLOAT_PAUSED: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
      state == speif_pkg::SPEIF_PAUSED |-> serial_out_oe_n)
      else $error("serial_out driven while paused");
   AST_FROZEN_PAUSE: assert property (@(posedge mclk) disable iff (sys_rst) // RULE13
      state == speif_pkg::SPEIF_PAUSED ##1 state == speif_pkg::SPEIF_PAUSED
      |-> $stable(bit_cnt) && $stable(shift_in))
      else $error("counters moved while paused");
   AST_RESUME_POS: assert property (@(posedge mclk) disable iff (sys_rst) // RULE8
      state == speif_pkg::SPEIF_PAUSED && pins.pause_n && !pins.select_n
      |=> state == speif_pkg::SPEIF_ACTIVE && $stable(bit_cnt))
      else $error("resume lost bit position");
   AST_SAMPLE_RISE: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
      state == speif_pkg::SPEIF_ACTIVE && !pins.select_n && pins.pause_n && sclk_rise
      |=> shift_in[0] == $past(pins.serial_in) && bit_cnt == $past(bit_cnt) + 3'h1)
      else $error("rising edge not sampled");
   AST_SHIFT_FALL: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
      !sclk_fall && state == speif_pkg::SPEIF_ACTIVE |=> $stable(serial_out))
      else $error("serial_out changed off a falling edge");
   AST_GUARD_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
      status_blocked && opcode == speif_pkg::CMD_WRITE_STATUS |-> !commit)
      else $error("guarded status write accepted");
   AST_WRITE_BUSY: assert property (@(posedge mclk) disable iff (sys_rst) // RULE11
      s_commit |=> write_busy ##1 wr_cnt < WRITE_CYCLES[31:0])
      else $error("internal write not timed");
   AST_GUARD_OPEN: assert property (@(posedge mclk) disable iff (sys_rst) // RULE5
      pins.write_guard_n |-> !status_blocked)
      else $error("guard pin high still inhibits");

endmodule : speif_core

//--- speif_host_model.sv
// host spi master model that drives the device pins of the eeprom interface
module speif_host_model (
   input  wire logic mclk,
   input  wire logic so_pin,
   output logic      select_n,
   output logic      sclk,
   output logic      serial_in,
   output logic      pause_n,
   output logic      so_paused
);
   timeunit 1ns;
   timeprecision 1ps;

   logic idle_lvl;

   initial begin
      select_n  = 1'b1;
      sclk      = 1'b0;
      serial_in = 1'b0;
      pause_n   = 1'b1;
      so_paused = 1'b0;
      idle_lvl  = 1'b0;
   end

   // half of a 160 ns link clock period
   task automatic half();
      repeat (8) @(negedge mclk);
   endtask : half

   task automatic open_frame(input logic cpol);
      idle_lvl = cpol;
      sclk     = cpol;
      half();
      select_n = 1'b0;
      half();
   endtask : open_frame

   task automatic close_frame();
      sclk = idle_lvl;
      half();
      select_n  = 1'b1;
      // data line no longer meaningful once deselected
      serial_in = ~serial_in;
      half();
   endtask : close_frame

   // sends d[7] first; samples the output at the moment the clock rises
   task automatic shift_bits(input logic [7:0] d, input int n, inout logic [7:0] q);
      for (int i = 0; i < n; i++) begin
         sclk      = 1'b0;
         serial_in = d[7-i];
         half();
         sclk = 1'b1;
         q    = {q[6:0], so_pin};
         half();
      end
   endtask : shift_bits

   // junk clocks and data while paused must leave the transfer untouched
   task automatic hold_pause(input int junk);
      sclk = 1'b0;
      half();
      pause_n = 1'b0;
      half();
      so_paused = so_pin;
      repeat (junk) begin
         sclk      = ~sclk;
         serial_in = 1'($urandom);
         half();
      end
      sclk = 1'b0;
      half();
      pause_n = 1'b1;
      half();
   endtask : hold_pause
endmodule : speif_host_model

//--- spi_eeprom_pin_interface_test.sv
// self-checking bench of the serial eeprom pin interface
module spi_eeprom_pin_interface_test;
   timeunit 1ns;
   timeprecision 1ps;

   // short counts keep the run brief; expectations follow from these
   localparam int unsigned WC = 20;
   localparam int unsigned PU = 10;

   logic       mclk, sys_rst, write_guard_n, serial_out, serial_out_oe_n;
   logic       rx_valid, rx_first, write_busy, ready;
   logic       select_n, sclk, serial_in, pause_n, so_paused;
   logic [7:0] tx_byte, rx_byte, status, mstatus;
   wire        so_pin;
   int         miscompares, compares;
   logic [8:0] exp_q[$];

   assign so_pin = serial_out_oe_n ? 1'bz : serial_out;

   speif_core #(.WRITE_CYCLES(WC), .POWERUP_CYCLES(PU)) u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .select_n(select_n), .sclk(sclk),
      .serial_in(serial_in), .pause_n(pause_n), .write_guard_n(write_guard_n),
      .tx_byte(tx_byte), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_first(rx_first),
      .write_busy(write_busy), .ready(ready), .status(status)
   );

   speif_host_model u_host (
      .mclk(mclk), .so_pin(so_pin), .select_n(select_n), .sclk(sclk),
      .serial_in(serial_in), .pause_n(pause_n), .so_paused(so_paused)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // comparison and verdict
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   // every received byte is matched against the model queue
   always @(negedge mclk) begin
      if (!sys_rst && rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check({rx_first, rx_byte}, 16'hffff);
         else check({rx_first, rx_byte}, exp_q.pop_front());
      end
   end

   // ---------------------------------------------------------------
   // one framed transaction: opcode, then nb bits of the second byte
   // ---------------------------------------------------------------
   task automatic run_frame(input logic [7:0] op, input logic [7:0] d, input logic cpol,
                            input int pause_at, input int nb);
      logic [7:0] q;
      logic       commit;
      int         cnt;
      q       = 8'h00;
      tx_byte = 8'($urandom);
      exp_q.push_back({1'b1, op});
      if (nb == 8) exp_q.push_back({1'b0, d});
      u_host.open_frame(cpol);
      u_host.shift_bits(op, 8, q);
      check(q, tx_byte);
      if (pause_at > 0) begin
         u_host.shift_bits(d, pause_at, q);
         u_host.hold_pause(4);
         check(so_paused, 1'bz);
         u_host.shift_bits(8'(d << pause_at), nb - pause_at, q);
         check(q, tx_byte);
      end else begin
         u_host.shift_bits(d, nb, q);
      end
      u_host.close_frame();
      check(so_pin, 1'bz);
      commit = (nb == 8) && (op == 8'h02
               || (op == 8'h01 && !(write_guard_n == 1'b0 && mstatus[7])));
      check(write_busy, commit);
      cnt = 8;
      while (write_busy === 1'b1 && cnt < WC + 20) begin
         @(negedge mclk);
         cnt++;
      end
      if (commit) check(cnt >= WC && cnt <= WC + 6, 1'b1);
      if (commit && op == 8'h01) mstatus = d;
      check(status, {mstatus[7:1], 1'b0});
   endtask : run_frame

   initial begin
      int cnt;
      int seed;
      seed          = $urandom(32'h619fce1c);
      sys_rst       = 1'b1;
      write_guard_n = 1'b1;
      tx_byte       = 8'h00;
      mstatus       = 8'h00;
      miscompares   = 0;
      compares      = 0;
      repeat (6) @(negedge mclk);
      check({serial_out_oe_n, ready, write_busy, status}, {3'b100, 8'h00});
      sys_rst = 1'b0;
      cnt     = 0;
      while (ready !== 1'b1 && cnt < PU + 10) begin
         @(negedge mclk);
         cnt++;
      end
      check(cnt >= PU && cnt <= PU + 2, 1'b1);
      run_frame(8'h02, 8'($urandom), 1'b0, 0, 8);
      run_frame(8'h02, 8'($urandom), 1'b1, 0, 8);
      run_frame(8'h03, 8'($urandom), 1'b0, 0, 8);
      run_frame(8'h01, 8'h80 | 8'($urandom), 1'b0, 3, 8);
      write_guard_n = 1'b0;
      run_frame(8'h01, 8'($urandom), 1'b0, 0, 8);
      run_frame(8'h02, 8'($urandom), 1'b1, 5, 8);
      write_guard_n = 1'b1;
      run_frame(8'h01, 8'($urandom), 1'b0, 0, 5);
      run_frame(8'h01, 8'h00, 1'b0, 0, 8);
      check(exp_q.size(), 0);
      give_verdict();
   end

   // the whole run needs well under 20000 cycles
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
endmodule : spi_eeprom_pin_interface_test
